// ---- rts_sequencer.v ----
// Purpose: Reset sequencing, power-up and start-up timers, phase strobes.
// Assumes: 100 MHz clock; oscillator pin much slower than clock/4.
// Notes:   Register access over APB, one wait-free access phase.
// Operation
// - Divide oscillator by four into phase strobes
// - RC mode drives clock output at osc/4
// - Phases frozen in phase one during reset
// - Park bus strobes in reset if external
// - Force port directions to input in reset
// - Reset-insensitive register keeps contents
// - Timeout and powerdown flags record reset cause
// - Hold reset while supply below trip point
// - Power-up timer starts at power-on or brown-out
// - Power-up timer on own RC tick; holds reset
// - Start-up timer counts 1024 oscillator cycles
// - Both timers run together; release after last
// - Start-up count only after amplitude qualified
// - Timers start only with master clear high
// - Power-on sets timeout and powerdown flags
`timescale 1ns/1ps
`include "rts_regs.vh"
module rts_sequencer #(
  parameter POWERUP_TIMER_TICKS = (`RTS_POWERUP_TIMER_MS * 1000000) / `RTS_RC_TICK_NS
) (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire        oscInputPin,
  input  wire        oscQualified,
  input  wire        supplyOk,
  input  wire        brownoutReset,
  input  wire        masterClearN,
  input  wire        watchdogReset,
  input  wire        sleepActive,
  input  wire        wakeEvent,
  output reg         coreResetN,
  output reg         portDirForce,
  output reg         phaseOne,
  output reg         phaseTwo,
  output reg         phaseThree,
  output reg         phaseFour,
  output reg         clockOutPin,
  output reg         clockOutOe,
  output reg         addrLatchOut,
  output reg         addrLatchOe,
  output reg         outEnableOut,
  output reg         outEnableOe,
  output reg         writeStrobeOut,
  output reg         writeStrobeOe
);

  localparam ST_POR    = 3'h0;
  localparam ST_TIMERS = 3'h1;
  localparam ST_RUN    = 3'h2;
  localparam ST_SLEEP  = 3'h3;
  localparam ST_HOLD   = 3'h4;
  localparam ST_OST    = 3'h5;

  localparam integer TICK_M1  = `RTS_RC_TICK_NS / `RTS_CLK_NS - 1;
  localparam integer POWERUP_TIMER_INT = POWERUP_TIMER_TICKS;
  localparam [6:0]  TICK_LAST = TICK_M1[6:0];
  localparam [16:0] POWERUP_TIMER_LAST = POWERUP_TIMER_INT[16:0];
  localparam [10:0] OST_LAST  = `RTS_OST_CYCLES;

  // Reset release through two flops
  reg rstMeta_reg;
  reg rstN;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg <= 1'b0;
      rstN        <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstN        <= rstMeta_reg;
    end
  end

  // Pin inputs into the clock domain
  wire [5:0] pinSync;
  rts_sync #(.WIDTH(6)) uPinSync (
    .clock   (clock),
    .rstN    (rstN),
    .asyncIn ({oscInputPin, oscQualified, supplyOk, brownoutReset,
               masterClearN, watchdogReset}),
    .syncOut (pinSync)
  );
  wire oscS    = pinSync[5];
  wire qualS   = pinSync[4];
  wire supS    = pinSync[3];
  wire brownS  = pinSync[2];
  wire mclrNS  = pinSync[1];
  wire wdtS    = pinSync[0];

  reg         oscPrev_reg;
  reg  [2:0]  state_reg, state_next;
  reg  [6:0]  tick_reg;
  reg  [16:0] powerup_timer_reg;
  reg  [10:0] ost_reg;
  reg  [1:0]  phase_reg;
  reg         fromSleep_reg, fromSleep_next;
  reg         ostHold_reg, ostHold_next;
  reg  [2:0]  ctrl_reg;
  reg  [3:0]  flags_reg, flags_next;
  reg  [`RTS_EV_WIDTH-1:0] event_reg, mask_reg, snap_reg, evSet;
  reg  [7:0]  keep_reg;
  reg  [31:0] readMux;
  reg         mapped;

  wire oscRise  = oscS & ~oscPrev_reg;
  wire rcTick   = (tick_reg == TICK_LAST);
  wire pwrtDone = (powerup_timer_reg == POWERUP_TIMER_LAST);
  wire ostDone  = (ost_reg == OST_LAST);
  wire [1:0] oscMode = ctrl_reg[`RTS_CTRL_MODE_HI:`RTS_CTRL_MODE_LO];
  wire xtal = (oscMode == `RTS_MODE_LF) | (oscMode == `RTS_MODE_XT);
  wire supplyBad = ~supS | brownS;
  wire inReset = (state_reg == ST_POR) | (state_reg == ST_TIMERS) |
                 (state_reg == ST_HOLD) | ((state_reg == ST_OST) & ostHold_reg);
  wire apbSetup  = psel & ~penable;
  wire apbAccess = psel & penable & pready;

  // Sequencer next state, cause flags and events
  always @* begin
    state_next     = state_reg;
    flags_next     = flags_reg;
    fromSleep_next = fromSleep_reg;
    ostHold_next   = ostHold_reg;
    evSet          = {`RTS_EV_WIDTH{1'b0}};
    if (apbAccess & pwrite & (paddr == `RTS_OFF_STATUS)) begin
      flags_next[`RTS_ST_BOR] = flags_reg[`RTS_ST_BOR] | pwdata[`RTS_ST_BOR];
      flags_next[`RTS_ST_POR] = flags_reg[`RTS_ST_POR] | pwdata[`RTS_ST_POR];
    end
    if (supplyBad) begin
      state_next = ST_POR;
      if (state_reg != ST_POR) begin
        flags_next[`RTS_ST_TO]  = 1'b1;
        flags_next[`RTS_ST_PD]  = 1'b1;
        flags_next[`RTS_ST_BOR] = 1'b0;
        if (!supS) begin
          flags_next[`RTS_ST_POR] = 1'b0;
        end
        evSet[`RTS_EV_BROWN] = brownS;
      end
    end else begin
      case (state_reg)
        ST_POR: begin
          if (mclrNS) begin
            state_next = ST_TIMERS;
          end
        end
        ST_TIMERS: begin
          if (!mclrNS) begin
            state_next = ST_POR;
          end else if (pwrtDone & ostDone) begin
            state_next = ST_RUN;
            evSet[`RTS_EV_RELEASE] = 1'b1;
          end
        end
        ST_RUN: begin
          if (!mclrNS) begin
            state_next     = ST_HOLD;
            fromSleep_next = 1'b0;
            flags_next[`RTS_ST_TO] = 1'b1;
            flags_next[`RTS_ST_PD] = 1'b1;
            evSet[`RTS_EV_MASTER_CLEAR_N] = 1'b1;
          end else if (wdtS) begin
            state_next     = ST_HOLD;
            fromSleep_next = 1'b0;
            flags_next[`RTS_ST_TO] = 1'b0;
            flags_next[`RTS_ST_PD] = 1'b1;
            evSet[`RTS_EV_WDT] = 1'b1;
          end else if (sleepActive) begin
            state_next = ST_SLEEP;
            flags_next[`RTS_ST_PD] = 1'b0;
          end
        end
        ST_SLEEP: begin
          if (!mclrNS) begin
            state_next     = ST_HOLD;
            fromSleep_next = 1'b1;
            flags_next[`RTS_ST_TO] = 1'b1;
            flags_next[`RTS_ST_PD] = 1'b0;
            evSet[`RTS_EV_MASTER_CLEAR_N] = 1'b1;
          end else if (wdtS | wakeEvent) begin
            state_next   = xtal ? ST_OST : ST_RUN;
            ostHold_next = 1'b0;
            flags_next[`RTS_ST_TO] = ~wdtS;
            flags_next[`RTS_ST_PD] = 1'b0;
            evSet[`RTS_EV_WAKE] = 1'b1;
          end
        end
        ST_HOLD: begin
          if (mclrNS & ~wdtS) begin
            ostHold_next = 1'b1;
            if (fromSleep_reg & xtal) begin
              state_next = ST_OST;
            end else begin
              state_next = ST_RUN;
              evSet[`RTS_EV_RELEASE] = 1'b1;
            end
          end
        end
        ST_OST: begin
          if (!mclrNS) begin
            state_next = ST_HOLD;
            evSet[`RTS_EV_MASTER_CLEAR_N] = 1'b1;
          end else if (ostDone) begin
            state_next = ST_RUN;
            evSet[`RTS_EV_RELEASE] = ostHold_reg;
          end
        end
        default: begin
          state_next = ST_POR;
        end
      endcase
    end
  end

  // State, flags; power-on sets timeout and powerdown
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state_reg     <= ST_POR;
      flags_reg     <= `RTS_FLAGS_RESET;
      fromSleep_reg <= 1'b0;
      ostHold_reg   <= 1'b0;
      oscPrev_reg   <= 1'b0;
    end else begin
      state_reg     <= state_next;
      flags_reg     <= flags_next;
      fromSleep_reg <= fromSleep_next;
      ostHold_reg   <= ostHold_next;
      oscPrev_reg   <= oscS;
    end
  end

  // Power-up timer on its own RC-rate tick; both timers clear on entry
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      tick_reg <= 7'h00;
      powerup_timer_reg <= 17'h00000;
      ost_reg  <= 11'h000;
    end else begin
      tick_reg <= rcTick ? 7'h00 : tick_reg + 7'h01;
      if (state_reg == ST_POR || state_reg == ST_RUN || state_reg == ST_SLEEP || state_reg == ST_HOLD) begin
        powerup_timer_reg <= 17'h00000;
        ost_reg  <= 11'h000;
      end else begin
        if (state_reg == ST_TIMERS && rcTick && !pwrtDone) begin
          powerup_timer_reg <= powerup_timer_reg + 17'h00001;
        end
        if ((state_reg == ST_TIMERS || state_reg == ST_OST) &&
            oscRise && qualS && !ostDone) begin
          ost_reg <= ost_reg + 11'h001;
        end
      end
    end
  end

  // Phase counter steps on each oscillator rising edge outside reset
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      phase_reg <= 2'h0;
    end else if (inReset) begin
      phase_reg <= 2'h0;
    end else if (oscRise) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Registered pin outputs; reset parks the external bus strobes
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      coreResetN     <= 1'b0;
      portDirForce   <= 1'b1;
      phaseOne       <= 1'b0;
      phaseTwo       <= 1'b0;
      phaseThree     <= 1'b0;
      phaseFour      <= 1'b0;
      clockOutPin    <= 1'b0;
      clockOutOe     <= 1'b0;
      addrLatchOut   <= 1'b0;
      addrLatchOe    <= 1'b0;
      outEnableOut   <= 1'b1;
      outEnableOe    <= 1'b0;
      writeStrobeOut <= 1'b1;
      writeStrobeOe  <= 1'b0;
    end else begin
      coreResetN     <= ~inReset;
      portDirForce   <= inReset;
      phaseOne       <= (phase_reg == 2'h0);
      phaseTwo       <= (phase_reg == 2'h1);
      phaseThree     <= (phase_reg == 2'h2);
      phaseFour      <= (phase_reg == 2'h3);
      clockOutPin    <= phase_reg[1];
      clockOutOe     <= (oscMode == `RTS_MODE_RC) | (oscMode == `RTS_MODE_EC);
      addrLatchOut   <= 1'b0;
      outEnableOut   <= 1'b1;
      writeStrobeOut <= 1'b1;
      addrLatchOe    <= inReset & ctrl_reg[`RTS_CTRL_EXTEXEC];
      outEnableOe    <= inReset & ctrl_reg[`RTS_CTRL_EXTEXEC];
      writeStrobeOe  <= inReset & ctrl_reg[`RTS_CTRL_EXTEXEC];
    end
  end

  // Read multiplexer
  always @* begin
    readMux = 32'h00000000;
    mapped  = 1'b1;
    case (paddr)
      `RTS_OFF_CTRL:   readMux[2:0] = ctrl_reg;
      `RTS_OFF_STATUS: readMux[4:0] = {inReset, flags_reg};
      `RTS_OFF_EVENT:  readMux[`RTS_EV_WIDTH-1:0] = event_reg;
      `RTS_OFF_MASK:   readMux[`RTS_EV_WIDTH-1:0] = mask_reg;
      `RTS_OFF_KEEP:   readMux[7:0] = keep_reg;
      `RTS_OFF_OSTCNT: readMux[10:0] = ost_reg;
      default:         mapped = 1'b0;
    endcase
  end

  // APB slave: data latched in setup, answer in first access cycle
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      ctrl_reg  <= `RTS_CTRL_RESET;
      mask_reg  <= {`RTS_EV_WIDTH{1'b0}};
      event_reg <= {`RTS_EV_WIDTH{1'b0}};
      snap_reg  <= {`RTS_EV_WIDTH{1'b0}};
      irq       <= 1'b0;
    end else begin
      pready  <= apbSetup;
      pslverr <= apbSetup & ~mapped;
      if (apbSetup) begin
        prdata   <= pwrite ? 32'h00000000 : readMux;
        snap_reg <= (!pwrite && paddr == `RTS_OFF_EVENT) ? event_reg : {`RTS_EV_WIDTH{1'b0}};
      end
      if (apbAccess & pwrite & (paddr == `RTS_OFF_CTRL)) begin
        ctrl_reg <= pwdata[2:0];
      end
      if (apbAccess & pwrite & (paddr == `RTS_OFF_MASK)) begin
        mask_reg <= pwdata[`RTS_EV_WIDTH-1:0];
      end
      // Clear only what was read; a new event wins over the clear
      if (apbAccess & ~pwrite) begin
        event_reg <= (event_reg & ~snap_reg) | evSet;
      end else begin
        event_reg <= event_reg | evSet;
      end
      irq <= |((event_reg | evSet) & mask_reg);
    end
  end

  // No reset on purpose: contents survive every reset but power-up
  always @(posedge clock) begin
    if (apbAccess & pwrite & (paddr == `RTS_OFF_KEEP)) begin
      keep_reg <= pwdata[7:0];
    end
  end

endmodule

// ---- rts_regs.vh ----
// Purpose: Constants for the reset and phase sequencer.
// Assumes: 100 MHz system clock, APB with 32-bit data.
// Notes:   Offsets are byte addresses.
`ifndef RTS_REGS_VH
`define RTS_REGS_VH

// Register offsets
`define RTS_OFF_CTRL    8'h00
`define RTS_OFF_STATUS  8'h04
`define RTS_OFF_EVENT   8'h08
`define RTS_OFF_MASK    8'h0c
`define RTS_OFF_KEEP    8'h10
`define RTS_OFF_OSTCNT  8'h14

// Control fields
`define RTS_CTRL_MODE_LO  0
`define RTS_CTRL_MODE_HI  1
`define RTS_CTRL_EXTEXEC  2
`define RTS_CTRL_RESET    3'h0

// Oscillator mode codes
`define RTS_MODE_LF  2'h0
`define RTS_MODE_XT  2'h1
`define RTS_MODE_EC  2'h2
`define RTS_MODE_RC  2'h3

// Status fields
`define RTS_ST_BOR     0
`define RTS_ST_POR     1
`define RTS_ST_PD      2
`define RTS_ST_TO      3
`define RTS_ST_INRST   4
`define RTS_FLAGS_RESET 4'hc

// Event fields
`define RTS_EV_RELEASE 0
`define RTS_EV_WDT     1
`define RTS_EV_MASTER_CLEAR_N    2
`define RTS_EV_BROWN   3
`define RTS_EV_WAKE    4
`define RTS_EV_WIDTH   5

// Timing
`define RTS_CLK_NS      10
`define RTS_RC_TICK_NS  1000
`define RTS_POWERUP_TIMER_MS     96
`define RTS_OST_CYCLES  11'h400

`endif

// ---- rts_sync.v ----
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Each bit is an independent level.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module rts_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock,
  input  wire             rstN,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_reg;

  // Both stages clear to zero, which reads as "held in reset"
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      stage1_reg <= {WIDTH{1'b0}};
      syncOut    <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end

endmodule

// ---- rts_sequencer_props.sv ----
// Purpose: Assertions on reset, phase and strobe outputs.
// Assumes: One clock domain, rst_b async low.
// Notes:   Bound to the sequencer top module.
`timescale 1ns/1ps
module rts_sequencer_props #(
  parameter POWERUP_TIMER_TICKS = 4
) (
  input wire clock,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire masterClearN,
  input wire supplyOk,
  input wire coreResetN,
  input wire portDirForce,
  input wire phaseOne,
  input wire phaseTwo,
  input wire phaseThree,
  input wire phaseFour,
  input wire clockOutPin,
  input wire addrLatchOut,
  input wire addrLatchOe,
  input wire outEnableOut,
  input wire outEnableOe,
  input wire writeStrobeOut,
  input wire writeStrobeOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Six cycles covers the two-flop sync plus state and output flops
  sequence s_master_clear_n_low;
    !masterClearN [*6];
  endsequence
  sequence s_supply_low;
    !supplyOk [*6];
  endsequence
  chk_phase_onehot: assert property (coreResetN && $past(coreResetN)
    |-> $onehot({phaseOne, phaseTwo, phaseThree, phaseFour})) else $error("phases not one-hot");
  chk_phase_advance: assert property ($rose(phaseTwo) |-> $past(phaseOne)) else $error("phase two out of order");
  chk_phase_wrap: assert property ($rose(phaseOne) && $past(coreResetN) |-> $past(phaseFour))
    else $error("phase one out of order");
  chk_phase_frozen: assert property (!coreResetN && !$past(coreResetN)
    |-> !phaseTwo && !phaseThree && !phaseFour) else $error("phases ran in reset");
  chk_clkout_low: assert property (coreResetN && ($past(phaseOne) || $past(phaseTwo))
    && (phaseOne || phaseTwo) |-> !clockOutPin) else $error("clock out high early");
  chk_strobe_park: assert property (addrLatchOe |-> !addrLatchOut && outEnableOut
    && writeStrobeOut && outEnableOe && writeStrobeOe) else $error("strobes not parked");
  chk_strobe_run: assert property (coreResetN && $past(coreResetN)
    |-> !addrLatchOe && !outEnableOe && !writeStrobeOe) else $error("strobes driven in run");
  chk_port_input: assert property ($past(coreResetN) == coreResetN
    |-> portDirForce == !coreResetN) else $error("port force wrong");
  chk_master_clear_n_hold: assert property (s_master_clear_n_low |=> !coreResetN) else $error("clear did not reset");
  chk_supply_hold: assert property (s_supply_low |=> !coreResetN) else $error("low supply ran");
  chk_release_cause: assert property ($rose(coreResetN)
    |-> $past(masterClearN, 4) && $past(supplyOk, 4)) else $error("release without clear high");
  chk_apb_pulse: assert property (psel && !penable |=> pready ##1 !pready) else $error("ready not one pulse");
endmodule
bind rts_sequencer rts_sequencer_props #(.POWERUP_TIMER_TICKS(POWERUP_TIMER_TICKS)) u_props (.*);

// ---- rts_partner.sv ----
// Purpose: Crystal model at the oscillator pin.
// Assumes: Amplitude builds up over a few periods.
// Notes:   Pin holds its last level while stopped.
`timescale 1ns/1ps
module rts_partner #(
  parameter HALF_NS    = 40,
  parameter BUILD_EDGE = 16
) (
  input  wire  run,
  output logic oscInputPin,
  output logic oscQualified
);
  int edges;
  // Qualify before the toggle so a watcher sees a settled flag
  initial begin
    oscInputPin  = 1'b0;
    oscQualified = 1'b0;
    edges        = 0;
    forever begin
      #(HALF_NS);
      if (run) begin
        oscQualified = (edges >= BUILD_EDGE);
        oscInputPin  = ~oscInputPin;
        edges        = edges + 1;
      end
    end
  end
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the reset and phase sequencer.
// Assumes: Power-up timer cut to 4 ticks, oscillator 12.5 MHz.
// Notes:   Start-up count outlasts the power-up timer here.
`timescale 1ns/1ps
`include "rts_regs.vh"
module tb_top;
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        oscInputPin, oscQualified, oscRun, err;
  logic        supplyOk, brownoutReset, masterClearN, watchdogReset;
  logic        sleepActive, wakeEvent, coreResetN, portDirForce;
  logic        phaseOne, phaseTwo, phaseThree, phaseFour;
  logic        clockOutPin, clockOutOe, addrLatchOut, addrLatchOe;
  logic        outEnableOut, outEnableOe, writeStrobeOut, writeStrobeOe;
  int          bad_count, checks, rises;

  rts_sequencer #(.POWERUP_TIMER_TICKS(4)) u_dut (.*);
  rts_partner u_osc (.run(oscRun), .oscInputPin(oscInputPin), .oscQualified(oscQualified));

  // Free-running system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Qualified oscillator rises, the start-up timer's reference
  always @(posedge oscInputPin) begin
    if (oscQualified) rises++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready rather than assuming latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h1, 32'h0);
  endtask

  task automatic wait_run(input int lim);
    int n;
    n = 0;
    while (coreResetN !== 1'b1 && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk(coreResetN, 1'b1);
  endtask

  task automatic t_power_up;
    apb(1'b1, `RTS_OFF_MASK, 32'h1f);
    apb(1'b1, `RTS_OFF_CTRL, 32'h7);
    supplyOk <= 1'b1;
    oscRun   <= 1'b1;
    repeat (2000) @(posedge clock);
    chk(coreResetN, 1'b0);
    masterClearN <= 1'b1;
    rises = 0;
    repeat (1000) @(posedge clock);
    chk({coreResetN, portDirForce, addrLatchOe}, 3'b011);
    wait_run(12000);
    chk(rises >= 1024 && rises <= 1026, 1'b1);
    chk(clockOutOe, 1'b1);
    apb(1'b0, `RTS_OFF_STATUS, 32'h0);
    chk(rd[4:0], 5'h0c);
    chk(irq, 1'b1);
    apb(1'b0, `RTS_OFF_EVENT, 32'h0);
    chk(rd[0], 1'b1);
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
  endtask

  // Source 0 clear pin, 1 watchdog, 2 brown-out
  task automatic t_reset_src(input int src, input logic [4:0] st, input logic [4:0] ev);
    @(posedge clock);
    masterClearN  <= (src != 0);
    watchdogReset <= (src == 1);
    brownoutReset <= (src == 2);
    repeat (10) @(posedge clock);
    chk({coreResetN, portDirForce, addrLatchOe}, 3'b011);
    masterClearN  <= 1'b1;
    watchdogReset <= 1'b0;
    brownoutReset <= 1'b0;
    rises = 0;
    wait_run(12000);
    if (src == 2) chk(rises >= 1024 && rises <= 1026, 1'b1);
    else chk(rises < 8, 1'b1);
    apb(1'b0, `RTS_OFF_STATUS, 32'h0);
    chk(rd[4:0], st);
    apb(1'b0, `RTS_OFF_EVENT, 32'h0);
    chk(rd[4:0] & ev, {27'h0, ev});
  endtask

  // Sleep then wake; crystal modes run the start-up count without a core reset
  task automatic t_sleep_wake(input logic [2:0] ctrl, input logic xt);
    apb(1'b1, `RTS_OFF_CTRL, {29'h0, ctrl});
    sleepActive <= 1'b1;
    repeat (4) @(posedge clock);
    chk(clockOutOe, !xt);
    sleepActive <= 1'b0;
    wakeEvent   <= 1'b1;
    @(posedge clock);
    wakeEvent   <= 1'b0;
    repeat (100) @(posedge clock);
    apb(1'b0, `RTS_OFF_OSTCNT, 32'h0);
    chk(rd != 32'h0, xt);
    chk(coreResetN, 1'b1);
    repeat (xt ? 8400 : 10) @(posedge clock);
    apb(1'b0, `RTS_OFF_OSTCNT, 32'h0);
    chk(rd, 32'h0);
    chk(coreResetN, 1'b1);
    apb(1'b0, `RTS_OFF_STATUS, 32'h0);
    chk(rd[4:0], 5'h0a);
    apb(1'b0, `RTS_OFF_EVENT, 32'h0);
    chk(rd[4], 1'b1);
  endtask

  task automatic wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence; supply and clear start low as at power-on
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {supplyOk, brownoutReset, watchdogReset, sleepActive, wakeEvent, oscRun} = '0;
    masterClearN = 1'b0;
    rst_b        = 1'b0;
    bad_count    = 0;
    checks       = 0;
    rises        = 0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    t_power_up;
    apb(1'b1, `RTS_OFF_KEEP, 32'ha5);
    apb(1'b1, `RTS_OFF_STATUS, 32'h3);
    t_reset_src(0, 5'h0f, 5'h05);
    t_reset_src(1, 5'h07, 5'h03);
    t_reset_src(2, 5'h0e, 5'h09);
    t_sleep_wake(3'h5, 1'b1);
    t_sleep_wake(3'h4, 1'b1);
    t_sleep_wake(3'h6, 1'b0);
    apb(1'b0, `RTS_OFF_KEEP, 32'h0);
    chk(rd[7:0], 8'ha5);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    wrap_up;
  end

  // Hang guard, well beyond the expected run length
  initial begin
    #800000;
    bad_count++;
    wrap_up;
  end
endmodule
